/* File: hw/mmx_pkg.sv */
/*
  Shared constants and types of the move and multiply execution unit.
  Assumes the decoder drives commands from the same clock and reset.
*/
package mmx_pkg;

	// Datapath widths
	localparam int        W_WIDTH    = 16;
	localparam int        NUM_W      = 16;
	localparam int        ACC_WIDTH  = 40;
	localparam int        PROD_WIDTH = 33;
	localparam int        DSR_WIDTH  = 10;
	localparam int        TBL_WIDTH  = 8;
	localparam int        LIT5_WIDTH = 5;
	localparam int        OVF_MSB    = 39;
	localparam int        OVF_LSB    = 31;

	// Fixed register roles
	localparam logic [3:0] DEF_WORK   = 4'h0;
	localparam logic [3:0] MULF_LO    = 4'h2;
	localparam logic [3:0] MULF_HI    = 4'h3;
	localparam logic [3:0] AWB_WORK   = 4'hd;

	// Cycle counts per instruction group
	localparam int        CYC_SINGLE = 1;
	localparam int        CYC_DOUBLE = 2;
	localparam int        CYC_SFR    = 1;

	// Register map, word addresses
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_FLAGS    = 8'h01;
	localparam logic [7:0] REG_IRQ_STAT = 8'h02;
	localparam logic [7:0] REG_IRQ_MASK = 8'h03;
	localparam logic [7:0] REG_DSR_PAGE = 8'h04;
	localparam logic [7:0] REG_TBL_PAGE = 8'h05;

	// Flag layout: {sat any, sat B, sat A, ovf any, ovf B, ovf A}
	localparam int        FLG_OVF_A   = 0;
	localparam int        FLG_OVF_B   = 1;
	localparam int        FLG_OVF_ANY = 2;
	localparam int        FLG_SAT_A   = 3;
	localparam int        FLG_SAT_B   = 4;
	localparam int        FLG_SAT_ANY = 5;

	// Interrupt event layout
	localparam int        EVT_OVF_A = 0;
	localparam int        EVT_OVF_B = 1;
	localparam int        EVT_SAT_A = 2;
	localparam int        EVT_SAT_B = 3;
	localparam int        EVT_SFR   = 4;
	localparam int        NUM_EVT   = 5;

	// Reset values
	localparam logic       CTRL_SAT_EN_RST = 1'b1;
	localparam logic [4:0] IRQ_MASK_RST    = 5'h00;

	typedef enum logic [4:0] {
		OP_NOP        = 5'h00,
		OP_MOV_W      = 5'h01,
		OP_MOV_LIT    = 5'h02,
		OP_MOV_F2W    = 5'h03,
		OP_MOV_W2F    = 5'h04,
		OP_DMOV_RD    = 5'h05,
		OP_DMOV_WR    = 5'h06,
		OP_PAG_LIT_DS = 5'h07,
		OP_PAG_LIT_TB = 5'h08,
		OP_PAG_W_DS   = 5'h09,
		OP_PAG_W_TB   = 5'h0a,
		OP_PREFETCH   = 5'h0b,
		OP_ACC_MUL    = 5'h0c,
		OP_ACC_NMUL   = 5'h0d,
		OP_ACC_MSUB   = 5'h0e,
		OP_MUL_PAIR   = 5'h0f,
		OP_MUL_ACC    = 5'h10,
		OP_MUL_WORD   = 5'h11,
		OP_MUL_FILE   = 5'h12
	} mmx_op_t;

	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_SECOND = 2'b01,
		PH_STALL  = 2'b10
	} mmx_phase_t;

endpackage

/* File: hw/mmx_mul_if.sv */
/*
  Operand and product bundle between the execution unit and its multiplier.
  Assumes purely combinational use within one clock domain.
*/
`timescale 1ns/1ps
interface mmx_mul_if;
	logic [15:0] a;
	logic [15:0] b;
	logic        aSigned;
	logic        bSigned;
	logic [32:0] prod;

	modport user (output a, output b, output aSigned, output bSigned, input prod);
	modport mult (input a, input b, input aSigned, input bSigned, output prod);
endinterface

/* File: hw/mmx_mult.sv */
/*
  16 by 16 multiplier with independent operand signedness, 33-bit signed product.
  Assumes the caller registers the result; no state is held here.
*/
`timescale 1ns/1ps
module mmx_mult (
	// Operand and product bundle
	mmx_mul_if.mult m
);
	import mmx_pkg::*;

	logic signed [16:0] opA;
	logic signed [16:0] opB;
	logic signed [33:0] full;

	////////////////////////////////////////////////////////////////////////
	// Extend each operand by one bit so every signedness pairing is one product
	always_comb begin
		opA  = $signed({m.aSigned & m.a[15], m.a});
		opB  = $signed({m.bSigned & m.b[15], m.b});
		full = opA * opB;
	end

	// Top bit is redundant: the widest case fits in 33 bits
	assign m.prod = full[PROD_WIDTH-1:0];
endmodule

/* File: hw/mmx_exec_unit.sv */
/*
  Move, page-load, accumulator prefetch/store and multiply execution unit.
  Holds the working registers, both accumulators, page registers and flags.
  Assumes the decoder presents one command at a time, synchronous to clk, and
  supplies memory operand words on cmdMemData in the cycle they are used.
*/
`timescale 1ns/1ps
module mmx_exec_unit #(
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      ce,
	// Command from decoder
	input  wire logic                      cmdValid,
	input  wire mmx_pkg::mmx_op_t          cmdOp,
	input  wire logic [3:0]                cmdDst,
	input  wire logic [3:0]                cmdSrc,
	input  wire logic [3:0]                cmdBase,
	input  wire logic [15:0]               cmdLit,
	input  wire logic                      cmdBSigned,
	input  wire logic                      cmdSSigned,
	input  wire logic                      cmdUseLit,
	input  wire logic                      cmdAccSel,
	input  wire logic                      cmdSfr,
	input  wire logic [15:0]               cmdMemData,
	// Operand prefetch and writeback
	input  wire logic                      cmdPfxEn,
	input  wire logic [3:0]                cmdPfxReg,
	input  wire logic [15:0]               cmdPfxData,
	input  wire logic                      cmdPfyEn,
	input  wire logic [3:0]                cmdPfyReg,
	input  wire logic [15:0]               cmdPfyData,
	input  wire logic                      cmdAwb,
	// Status toward decoder and memory
	output logic                           cmdReady,
	output logic                           opDone,
	output logic                           memWe,
	output logic [15:0]                    memWdata,
	output logic [mmx_pkg::DSR_WIDTH-1:0]  dsrPage,
	output logic [mmx_pkg::TBL_WIDTH-1:0]  tblPage,
	output logic [5:0]                     accFlags,
	output logic                           irq,
	// Register port
	input  wire logic [ADDR_W-1:0]         regAddr,
	input  wire logic [15:0]               regWdata,
	input  wire logic                      regWr,
	input  wire logic                      regRd,
	output logic [15:0]                    regRdata
);
	import mmx_pkg::*;

	typedef struct packed {
		logic [NUM_W-1:0][W_WIDTH-1:0] default_working_reg;
		logic [1:0][ACC_WIDTH-1:0]     acc;
		logic [DSR_WIDTH-1:0]          dsrPage;
		logic [TBL_WIDTH-1:0]          tblPage;
		logic [5:0]                    flags;
		logic [NUM_EVT-1:0]            irqStat;
		logic [NUM_EVT-1:0]            irqMask;
		logic                          satEn;
		mmx_phase_t                    phase;
		mmx_op_t                       pendOp;
		logic [3:0]                    pendReg;
		logic                          pendSfr;
		logic                          cmdReady;
		logic                          opDone;
		logic                          memWe;
		logic [15:0]                   memWdata;
		logic                          irq;
		logic [15:0]                   rdData;
	} mmx_state_t;

	localparam mmx_state_t STATE_RST = '{
		default_working_reg:     '0,
		acc:      '0,
		dsrPage:  '0,
		tblPage:  '0,
		flags:    '0,
		irqStat:  '0,
		irqMask:  IRQ_MASK_RST,
		satEn:    CTRL_SAT_EN_RST,
		phase:    PH_IDLE,
		pendOp:   OP_NOP,
		pendReg:  '0,
		pendSfr:  1'b0,
		cmdReady: 1'b1,
		opDone:   1'b0,
		memWe:    1'b0,
		memWdata: '0,
		irq:      1'b0,
		rdData:   '0
	};

	localparam logic [ACC_WIDTH-1:0] ACC_MAX = {1'b0, {(ACC_WIDTH-1){1'b1}}};
	localparam logic [ACC_WIDTH-1:0] ACC_MIN = {1'b1, {(ACC_WIDTH-1){1'b0}}};

	mmx_state_t q;
	mmx_state_t d;

	mmx_mul_if mul ();

	// Working values of the accumulator path, command take and events
	logic [ACC_WIDTH-1:0] prodExt;
	logic [ACC_WIDTH:0]   accWide;
	logic [ACC_WIDTH-1:0] accNew;
	logic                 accSat;
	logic                 take;
	logic                 isMac;
	logic [NUM_EVT-1:0]   evt;

	// Overflow means bits above the 32-bit product range disagree with its sign
	function automatic logic accOvf(input logic [ACC_WIDTH-1:0] v);
		accOvf = !((&v[OVF_MSB:OVF_LSB]) || !(|v[OVF_MSB:OVF_LSB]));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Multiplier operand selection
	mmx_mult u_mult (
		.m (mul.mult)
	);

	always_comb begin
		mul.a       = q.default_working_reg[cmdBase];
		mul.b       = q.default_working_reg[cmdSrc];
		mul.aSigned = cmdBSigned;
		mul.bSigned = cmdSSigned;
		if (cmdUseLit) begin
			mul.b       = {11'h000, cmdLit[LIT5_WIDTH-1:0]};
			mul.bSigned = 1'b0;
		end
		if (cmdOp == OP_ACC_MUL || cmdOp == OP_ACC_NMUL || cmdOp == OP_ACC_MSUB) begin
			mul.aSigned = 1'b1;
			mul.bSigned = 1'b1;
		end
		if (cmdOp == OP_MUL_FILE) begin
			mul.a = cmdMemData;
			mul.b = q.default_working_reg[DEF_WORK];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Accumulator arithmetic with optional saturation
	always_comb begin
		prodExt = {{(ACC_WIDTH-PROD_WIDTH){mul.prod[PROD_WIDTH-1]}}, mul.prod};
		unique case (cmdOp)
			OP_ACC_MSUB: accWide = {q.acc[cmdAccSel][ACC_WIDTH-1], q.acc[cmdAccSel]}
			                       - {prodExt[ACC_WIDTH-1], prodExt};
			OP_ACC_NMUL: accWide = {(ACC_WIDTH+1){1'b0}} - {prodExt[ACC_WIDTH-1], prodExt};
			default:     accWide = {prodExt[ACC_WIDTH-1], prodExt};
		endcase
		accSat = q.satEn && (accWide[ACC_WIDTH] != accWide[ACC_WIDTH-1]);
		if (accSat) begin
			accNew = accWide[ACC_WIDTH] ? ACC_MIN : ACC_MAX;
		end else begin
			accNew = accWide[ACC_WIDTH-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus, sequencing and datapath writes
	always_comb begin
		d        = q;
		d.opDone = 1'b0;
		d.memWe  = 1'b0;
		d.rdData = '0;
		evt      = '0;
		take     = cmdValid && q.cmdReady && q.phase == PH_IDLE;
		isMac    = cmdOp == OP_ACC_MUL || cmdOp == OP_ACC_MSUB;

		// Register reads answer in the next cycle; unmapped reads return zero
		if (regRd) begin
			unique case (regAddr)
				ADDR_W'(REG_CTRL):     d.rdData = {15'h0000, q.satEn};
				ADDR_W'(REG_FLAGS):    d.rdData = {10'h000, q.flags};
				ADDR_W'(REG_IRQ_STAT): d.rdData = {11'h000, q.irqStat};
				ADDR_W'(REG_IRQ_MASK): d.rdData = {11'h000, q.irqMask};
				ADDR_W'(REG_DSR_PAGE): d.rdData = {6'h00, q.dsrPage};
				ADDR_W'(REG_TBL_PAGE): d.rdData = {8'h00, q.tblPage};
				default:               d.rdData = '0;
			endcase
		end

		// Register writes; datapath writes below override in the same cycle
		if (regWr) begin
			unique case (regAddr)
				ADDR_W'(REG_CTRL):     d.satEn   = regWdata[0];
				ADDR_W'(REG_FLAGS):    begin
					d.flags[FLG_SAT_A] = q.flags[FLG_SAT_A] & ~regWdata[FLG_SAT_A];
					d.flags[FLG_SAT_B] = q.flags[FLG_SAT_B] & ~regWdata[FLG_SAT_B];
				end
				ADDR_W'(REG_IRQ_STAT): d.irqStat = q.irqStat & ~regWdata[NUM_EVT-1:0];
				ADDR_W'(REG_IRQ_MASK): d.irqMask = regWdata[NUM_EVT-1:0];
				ADDR_W'(REG_DSR_PAGE): d.dsrPage = regWdata[DSR_WIDTH-1:0];
				ADDR_W'(REG_TBL_PAGE): d.tblPage = regWdata[TBL_WIDTH-1:0];
				default:               ;
			endcase
		end

		unique case (q.phase)
			PH_IDLE: begin
				if (take) begin
					// operand prefetch into X and Y registers
					if (cmdOp == OP_PREFETCH || isMac || cmdOp == OP_ACC_NMUL) begin
						if (cmdPfxEn) begin
							d.default_working_reg[cmdPfxReg] = cmdPfxData;
						end
						if (cmdPfyEn) begin
							d.default_working_reg[cmdPfyReg] = cmdPfyData;
						end
					end
					if ((cmdOp == OP_PREFETCH || cmdOp == OP_ACC_MSUB) && cmdAwb) begin
						d.default_working_reg[AWB_WORK] = q.acc[!cmdAccSel][31:16];
					end
					unique case (cmdOp)
						OP_MOV_W:      d.default_working_reg[cmdDst] = q.default_working_reg[cmdSrc];
						OP_MOV_LIT:    d.default_working_reg[cmdDst] = cmdLit;
						OP_MOV_F2W:    d.default_working_reg[cmdDst] = cmdMemData;
						OP_MOV_W2F:    begin
							d.memWe    = 1'b1;
							d.memWdata = q.default_working_reg[cmdSrc];
						end
						// first word of a pair read out
						OP_DMOV_RD:    begin
							d.memWe    = 1'b1;
							d.memWdata = q.default_working_reg[cmdSrc];
						end
						// low word to the named register
						OP_DMOV_WR:    d.default_working_reg[cmdDst] = cmdMemData;
						OP_PAG_LIT_DS: d.dsrPage = cmdLit[DSR_WIDTH-1:0];
						OP_PAG_LIT_TB: d.tblPage = cmdLit[TBL_WIDTH-1:0];
						OP_PAG_W_DS:   d.dsrPage = q.default_working_reg[cmdSrc][DSR_WIDTH-1:0];
						OP_PAG_W_TB:   d.tblPage = q.default_working_reg[cmdSrc][TBL_WIDTH-1:0];
						OP_ACC_MUL,
						OP_ACC_MSUB:   begin
							d.acc[cmdAccSel] = accNew;
							if (accSat) begin
								d.flags[FLG_SAT_A + 32'(cmdAccSel)] = 1'b1;
								evt[EVT_SAT_A + 32'(cmdAccSel)] = 1'b1;
							end
							d.flags[FLG_OVF_A] = accOvf(cmdAccSel ? q.acc[0] : accNew);
							d.flags[FLG_OVF_B] = accOvf(cmdAccSel ? accNew : q.acc[1]);
							evt[EVT_OVF_A]  = d.flags[FLG_OVF_A];
							evt[EVT_OVF_B]  = d.flags[FLG_OVF_B];
						end
						OP_ACC_NMUL:   d.acc[cmdAccSel] = accNew;
						// low half named, high half next
						OP_MUL_PAIR:   begin
							d.default_working_reg[cmdDst]         = mul.prod[15:0];
							d.default_working_reg[4'(cmdDst + 1)] = mul.prod[31:16];
						end
						OP_MUL_ACC:    d.acc[cmdAccSel] = prodExt;
						OP_MUL_WORD:   d.default_working_reg[cmdDst] = mul.prod[15:0];
						OP_MUL_FILE:   begin
							d.default_working_reg[MULF_LO] = mul.prod[15:0];
							d.default_working_reg[MULF_HI] = mul.prod[31:16];
						end
						default:       ;
					endcase
					d.pendOp  = cmdOp;
					d.pendReg = (cmdOp == OP_DMOV_RD) ? cmdSrc : cmdDst;
					d.pendSfr = cmdSfr;
					if (cmdOp == OP_DMOV_RD || cmdOp == OP_DMOV_WR) begin
						d.phase = PH_SECOND;
					// extra cycle for outside special register
					end else if (cmdSfr) begin
						d.phase = PH_STALL;
					end else begin
						d.opDone = 1'b1;
					end
				end
			end
			PH_SECOND: begin
				// second word uses the next register
				if (q.pendOp == OP_DMOV_RD) begin
					d.memWe    = 1'b1;
					d.memWdata = q.default_working_reg[4'(q.pendReg + 1)];
				end else begin
					d.default_working_reg[4'(q.pendReg + 1)] = cmdMemData;
				end
				if (q.pendSfr) begin
					d.phase = PH_STALL;
				end else begin
					d.phase  = PH_IDLE;
					d.opDone = 1'b1;
				end
			end
			PH_STALL: begin
				evt[EVT_SFR] = 1'b1;
				d.phase      = PH_IDLE;
				d.opDone     = 1'b1;
			end
			default: d.phase = PH_IDLE;
		endcase

		// Combined flags follow the per-accumulator bits
		d.flags[FLG_OVF_ANY] = d.flags[FLG_OVF_A] | d.flags[FLG_OVF_B];
		d.flags[FLG_SAT_ANY] = d.flags[FLG_SAT_A] | d.flags[FLG_SAT_B];

		// Set wins over a clear written in the same cycle
		d.irqStat  = d.irqStat | evt;
		d.irq      = |(d.irqStat & d.irqMask);
		d.cmdReady = d.phase == PH_IDLE;
	end

	////////////////////////////////////////////////////////////////////////
	// State register; a low enable freezes everything including read data
	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= STATE_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign cmdReady = q.cmdReady;
	assign opDone   = q.opDone;
	assign memWe    = q.memWe;
	assign memWdata = q.memWdata;
	assign dsrPage  = q.dsrPage;
	assign tblPage  = q.tblPage;
	assign accFlags = q.flags;
	assign irq      = q.irq;
	assign regRdata = q.rdData;
endmodule

/* File: test/mmx_mem_model.sv */
/*
  Data memory stand-in: keeps the last two words the unit stores.
  Assumes stores arrive as one-cycle memWe pulses on clk.
*/
`timescale 1ns/1ps
module mmx_mem_model (
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Store port from the unit
	input wire logic        memWe,
	input wire logic [15:0] memWdata
);
	logic [15:0] last;
	logic [15:0] prev;
	////////////////////////////////////////
	// keeps pair order
	// Two deep, so a double store can be checked word by word
	always_ff @(posedge clk) begin
		if (!nrst) begin
			last <= 16'h0000;
			prev <= 16'h0000;
		end else if (memWe) begin
			last <= memWdata;
			prev <= last;
		end
	end
endmodule

/* File: test/mmx_exec_props.sv */
/*
  Checker for the move and multiply unit, bound to its top ports.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module mmx_exec_props #(
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input wire logic                     clk,
	input wire logic                     nrst,
	input wire logic                     ce,
	// Command
	input wire logic                     cmdValid,
	input wire mmx_pkg::mmx_op_t         cmdOp,
	input wire logic [15:0]              cmdLit,
	input wire logic                     cmdSfr,
	// Status
	input wire logic                     cmdReady,
	input wire logic                     opDone,
	input wire logic [mmx_pkg::DSR_WIDTH-1:0] dsrPage,
	input wire logic [mmx_pkg::TBL_WIDTH-1:0] tblPage,
	input wire logic [5:0]               accFlags,
	// Register port
	input wire logic [ADDR_W-1:0]        regAddr,
	input wire logic                     regWr,
	input wire logic                     regRd,
	input wire logic [15:0]              regRdata
);
	import mmx_pkg::*;
	logic       take;
	logic       dmov;
	logic       keep;
	logic       pag;
	logic [9:0] litDs;
	logic [7:0] litTb;
	////////////////////////////////////////
	// Decode of the command taken at this edge
	assign take = cmdValid && cmdReady && ce;
	assign dmov = cmdOp inside {OP_DMOV_RD, OP_DMOV_WR};
	assign keep = !(cmdOp inside {OP_ACC_MUL, OP_ACC_MSUB});
	assign pag = cmdOp inside {OP_PAG_LIT_DS, OP_PAG_LIT_TB, OP_PAG_W_DS, OP_PAG_W_TB};
	assign litDs = cmdLit[9:0];
	assign litTb = cmdLit[7:0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	a_single_done: assert property (
		take && !dmov && !cmdSfr |=> opDone && cmdReady) else $error("single op late");
	a_double_two: assert property (
		take && dmov && !cmdSfr |=> !cmdReady && !opDone ##1 opDone && cmdReady)
		else $error("double op timing");
	a_sfr_stall: assert property (
		take && !dmov && cmdSfr |=> !cmdReady && !opDone ##1 opDone)
		else $error("no stall cycle");
	a_flags_hold: assert property (
		take && keep && !regWr |=> accFlags == $past(accFlags)) else $error("flags moved");
	a_page_ds: assert property (
		take && cmdOp == OP_PAG_LIT_DS && !regWr |=> dsrPage == $past(litDs))
		else $error("read page wrong");
	a_page_tb: assert property (
		take && cmdOp == OP_PAG_LIT_TB && !regWr |=> tblPage == $past(litTb))
		else $error("table page wrong");
	a_pages_stay: assert property (
		!(take && pag) && !regWr |=> $stable(dsrPage) && $stable(tblPage))
		else $error("page changed");
	a_flag_union: assert property (
		accFlags[FLG_OVF_ANY] == (accFlags[FLG_OVF_A] || accFlags[FLG_OVF_B]) &&
		accFlags[FLG_SAT_ANY] == (accFlags[FLG_SAT_A] || accFlags[FLG_SAT_B]))
		else $error("union flag");
	a_rd_page: assert property (
		regRd && ce && regAddr == REG_DSR_PAGE |=> regRdata == {6'h00, $past(dsrPage)})
		else $error("page readback");
endmodule

/* File: test/testbench.sv */
/*
  Self-checking bench for the move and multiply unit.
  Assumes the unit accepts a command whenever it is idle.
*/
`timescale 1ns/1ps
module testbench;
	import mmx_pkg::*;
	localparam int ADDR_W = 8;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic cmdValid = 1'b0, cmdBSigned = 1'b0, cmdSSigned = 1'b0, cmdUseLit = 1'b0;
	logic cmdAccSel = 1'b0, cmdSfr = 1'b0, cmdPfxEn = 1'b0, cmdPfyEn = 1'b0, cmdAwb = 1'b0;
	mmx_op_t cmdOp = OP_NOP;
	logic [3:0] cmdDst = 4'h0, cmdSrc = 4'h0, cmdBase = 4'h0, cmdPfxReg = 4'h0, cmdPfyReg = 4'h0;
	logic [15:0] cmdLit = 16'h0000, cmdMemData = 16'h0000, cmdPfxData = 16'h0000;
	logic [15:0] cmdPfyData = 16'h0000, regWdata = 16'h0000;
	logic [7:0] regAddr = 8'h00;
	logic regWr = 1'b0, regRd = 1'b0;
	logic cmdReady, opDone, memWe, irq;
	logic [15:0] memWdata, regRdata;
	logic [9:0] dsrPage;
	logic [7:0] tblPage;
	logic [5:0] accFlags;
	int err_count = 0;
	int check_count = 0;
	logic [31:0] prod [4] = '{32'hfffc0004, 32'hfffe0004, 32'hfffe0004, 32'h00000004};
	////////////////////////////////////////
	mmx_exec_unit #(.ADDR_W(ADDR_W)) u_dut (
		.clk, .nrst, .ce, .cmdValid, .cmdOp, .cmdDst, .cmdSrc, .cmdBase, .cmdLit,
		.cmdBSigned, .cmdSSigned, .cmdUseLit, .cmdAccSel, .cmdSfr, .cmdMemData,
		.cmdPfxEn, .cmdPfxReg, .cmdPfxData, .cmdPfyEn, .cmdPfyReg, .cmdPfyData, .cmdAwb,
		.cmdReady, .opDone, .memWe, .memWdata, .dsrPage, .tblPage, .accFlags, .irq,
		.regAddr, .regWdata, .regWr, .regRd, .regRdata);
	mmx_mem_model u_mem (.clk, .nrst, .memWe, .memWdata);
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(regRdata, exp);
	endtask
	task automatic opt(input logic bs = 0, ss = 0, ul = 0, acs = 0, special_function_register = 0, awb = 0);
		@(posedge clk);
		cmdBSigned <= bs;
		cmdSSigned <= ss;
		cmdUseLit <= ul;
		cmdAccSel <= acs;
		cmdSfr <= special_function_register;
		cmdAwb <= awb;
	endtask
	// Issues one command and counts cycles up to its done pulse
	task automatic go(input mmx_op_t op, input int cyc, input logic [3:0] d = 0, s = 0,
		b = 0, input logic [15:0] l = 0, m0 = 0, m1 = 0);
		int n;
		@(posedge clk);
		cmdOp <= op;
		cmdDst <= d;
		cmdSrc <= s;
		cmdBase <= b;
		cmdLit <= l;
		cmdMemData <= m0;
		cmdValid <= 1'b1;
		@(posedge clk);
		cmdValid <= 1'b0;
		cmdMemData <= m1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (opDone !== 1'b1 && n < 8);
		chk(n, cyc);
	endtask
	// Working registers are seen only by storing them
	task automatic st(input logic [3:0] r, input logic [15:0] exp);
		go(OP_MOV_W2F, 1, 4'h0, r);
		@(negedge clk);
		chk(u_mem.last, exp);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	// Watchdog, far beyond the roughly 1200 cycles the tests need
	initial begin
		repeat (6000) @(posedge clk);
		err_count++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(REG_CTRL, 16'h0001);
		rd(REG_IRQ_MASK, 16'h0000);
		wr(8'h0f, 16'hffff);
		rd(8'h0f, 16'h0000);
		chk(cmdReady, 1'b1);
		$display("test reset done");
		go(OP_MOV_LIT, 1, 4'h1, 0, 0, 16'hfffe);
		go(OP_MOV_W, 1, 4'h5, 4'h1);
		go(OP_MOV_F2W, 1, 4'h6, 0, 0, 0, 16'h5a5a);
		go(OP_MOV_LIT, 1, 4'h9, 0, 0, 16'h7777);
		st(4'h5, 16'hfffe);
		st(4'h6, 16'h5a5a);
		go(OP_DMOV_WR, 2, 4'he, 0, 0, 0, 16'h1111, 16'h2222);
		go(OP_DMOV_RD, 2, 0, 4'he);
		@(negedge clk);
		chk(u_mem.prev, 16'h1111);
		chk(u_mem.last, 16'h2222);
		$display("test moves done");
		go(OP_PAG_LIT_DS, 1, 0, 0, 0, 16'h03ff);
		chk(dsrPage, 10'h3ff);
		go(OP_PAG_LIT_TB, 1, 0, 0, 0, 16'h00a5);
		chk(tblPage, 8'ha5);
		go(OP_MOV_LIT, 1, 4'h3, 0, 0, 16'hfedc);
		go(OP_PAG_W_DS, 1, 0, 4'h3);
		go(OP_PAG_W_TB, 1, 0, 4'h3);
		rd(REG_DSR_PAGE, 16'h02dc);
		rd(REG_TBL_PAGE, 16'h00dc);
		$display("test pages done");
		for (int i = 0; i < 4; i++) begin
			opt(i[1], i[0]);
			go(OP_MUL_PAIR, 1, 4'h6, 4'h5, 4'h1);
			st(4'h6, prod[i][15:0]);
			st(4'h7, prod[i][31:16]);
		end
		opt(1'b1, 1'b0, 1'b1);
		go(OP_MUL_PAIR, 1, 4'h6, 0, 4'h1, 16'h001f);
		st(4'h7, 16'hffff);
		st(4'h6, 16'hffc2);
		opt(1'b0, 1'b0, 1'b1);
		go(OP_MUL_PAIR, 1, 4'h6, 0, 4'h1, 16'h001f);
		st(4'h7, 16'h001e);
		opt(1'b1, 1'b1);
		go(OP_MUL_WORD, 1, 4'h8, 4'h5, 4'h1);
		st(4'h8, 16'h0004);
		st(4'h9, 16'h7777);
		opt();
		go(OP_MOV_LIT, 1, 4'h0, 0, 0, 16'h0100);
		go(OP_MUL_FILE, 1, 0, 0, 0, 0, 16'h0010);
		st(4'h2, 16'h1000);
		st(4'h3, 16'h0000);
		$display("test multiply done");
		// Third subtraction of 2^30 leaves the 32-bit range of acc A
		wr(REG_IRQ_MASK, 16'h0001);
		go(OP_MOV_LIT, 1, 4'ha, 0, 0, 16'h8000);
		go(OP_MOV_LIT, 1, 4'hb, 0, 0, 16'h0002);
		repeat (3) go(OP_ACC_MSUB, 1, 0, 4'ha, 4'ha);
		chk(accFlags, 6'h05);
		rd(REG_IRQ_STAT, 16'h0001);
		chk(irq, 1'b1);
		wr(REG_IRQ_STAT, 16'h0001);
		rd(REG_IRQ_STAT, 16'h0000);
		chk(irq, 1'b0);
		opt(0, 0, 0, 1);
		go(OP_ACC_NMUL, 1, 0, 4'hb, 4'ha);
		chk(accFlags, 6'h05);
		@(posedge clk);
		cmdPfxReg <= 4'h4;
		cmdPfxData <= 16'h1234;
		cmdPfyReg <= 4'hc;
		cmdPfyData <= 16'h4321;
		cmdPfxEn <= 1'b1;
		cmdPfyEn <= 1'b1;
		opt(0, 0, 0, 0, 0, 1);
		go(OP_PREFETCH, 1);
		@(posedge clk);
		cmdPfxEn <= 1'b0;
		cmdPfyEn <= 1'b0;
		st(4'hd, 16'h0001);
		st(4'h4, 16'h1234);
		st(4'hc, 16'h4321);
		opt();
		go(OP_ACC_MUL, 1, 0, 4'ha, 4'ha);
		chk(accFlags, 6'h00);
		opt(0, 0, 0, 1, 0, 1);
		go(OP_PREFETCH, 1);
		st(4'hd, 16'h4000);
		opt(1, 1, 0, 1);
		go(OP_MUL_ACC, 1, 0, 4'ha, 4'hb);
		opt(0, 0, 0, 0, 0, 1);
		go(OP_PREFETCH, 1);
		st(4'hd, 16'hffff);
		chk(accFlags, 6'h00);
		$display("test dsp done");
		wr(REG_IRQ_MASK, 16'h0010);
		opt(0, 0, 0, 0, 1);
		go(OP_MOV_LIT, 2, 4'h1, 0, 0, 16'h0abc);
		opt();
		rd(REG_IRQ_STAT, 16'h0010);
		chk(irq, 1'b1);
		st(4'h1, 16'h0abc);
		$display("test stall done");
		// Acc A holds 2^30; the 514th subtraction of 2^30 leaves the 40-bit range
		repeat (514) go(OP_ACC_MSUB, 1, 0, 4'ha, 4'ha);
		chk(accFlags, 6'h2d);
		wr(REG_FLAGS, 16'h0008);
		rd(REG_FLAGS, 16'h0005);
		$display("test saturate done");
		results();
	end
endmodule
bind mmx_exec_unit mmx_exec_props #(.ADDR_W(ADDR_W)) u_props (
	.clk, .nrst, .ce, .cmdValid, .cmdOp, .cmdLit, .cmdSfr, .cmdReady, .opDone,
	.dsrPage, .tblPage, .accFlags, .regAddr, .regWr, .regRd, .regRdata);
